// ===== peripheral_irq_aggregation.sv
// Per-peripheral interrupt flags, enables and request line routing.
// How it works
// - A source's interrupt condition sets its flag bit in the flag register.
// - Writing one to an enable-set bit enables that single source.
// - Writing one to an enable-clear bit disables that source; shared mask.
// - Request stands only while some source has flag and enable both set.
// - All requests of one peripheral are ORed into its single line.
// - Lines 0 to 8 carry power manager through event system in fixed order.
// - Serial interfaces 0 to 5 drive lines 9 to 14 ascending.
// - Control timers drive 15 to 17; basic timers 3 to 7 drive 18 to 22.
// - ADC 23, comparator 24, DAC 25, touch 26, I2S 27.
// - The external non-maskable source drives the non-maskable request.
`timescale 1ns/100ps
`include "irq_defines.svh"

module peripheral_irq_aggregation #(
	parameter int SRC_W = `IRQ_SRC_W,
	parameter int NUM_LINES = `IRQ_NUM_LINES
) (
	input wire logic clk_sys_in, // System clock, 125 MHz.
	input wire logic rst_in, // Asynchronous reset, active high.
	input irq_pkg::periph_events_t events_in, // Peripheral event pulses.
	input irq_pkg::sw_access_t sw_in, // Software register access.
	output logic [SRC_W-1:0] rd_data_out, // Registered read data.
	output logic rd_valid_out, // Read data valid, one cycle.
	output logic [NUM_LINES-1:0] irq_lines_out, // Numbered request lines.
	output logic nmi_req_out // Non-maskable request.
);

	import irq_pkg::*;

	localparam int NUM_SLOTS = `IRQ_NUM_SLOTS;

	src_vec_t slot_ev [NUM_SLOTS];
	src_vec_t flag_all [NUM_SLOTS];
	src_vec_t en_all [NUM_SLOTS];
	logic [NUM_SLOTS-1:0] req_all;
	logic [SRC_W-1:0] rd_data_reg;
	logic [SRC_W-1:0] rd_data_next;
	logic rd_valid_reg;

	////////////////////////////////////////////////////////////////
	// True when the current access writes register sel of slot s.
	function automatic logic sw_hit(input sw_access_t acc, input int s, input reg_sel_t sel);
		sw_hit = acc.wr && (acc.slot == s[`IRQ_LINE_IDX_W-1:0]) && (acc.sel == sel);
	endfunction

	////////////////////////////////////////////////////////////////
	// Routes each peripheral's events to the slot of its line.
	always_comb
	begin
		for (int i = 0; i < NUM_SLOTS; i++)
			slot_ev[i] = '0;
		slot_ev[`LINE_POWER_MANAGER] = events_in.power_manager;
		slot_ev[`LINE_SYSTEM_CONTROL] = events_in.system_control;
		slot_ev[`LINE_WATCHDOG] = events_in.watchdog;
		slot_ev[`LINE_RTC] = events_in.rtc;
		slot_ev[`LINE_EXTERNAL_IRQ_UNIT] = events_in.external_irq_unit;
		slot_ev[`LINE_FLASH_CONTROLLER] = events_in.flash_controller;
		slot_ev[`LINE_DMA_CONTROLLER] = events_in.dma_controller;
		slot_ev[`LINE_USB] = events_in.usb;
		slot_ev[`LINE_EVENT_SYSTEM] = events_in.event_system;
		for (int k = 0; k < `NUM_SERIAL_IFACE; k++)
			slot_ev[`LINE_SERIAL_IFACE_0 + k] = events_in.serial_iface[k];
		for (int k = 0; k < `NUM_CONTROL_TIMER; k++)
			slot_ev[`LINE_CONTROL_TIMER_0 + k] = events_in.control_timer[k];
		for (int k = 0; k < `NUM_BASIC_TIMER; k++)
			slot_ev[`LINE_BASIC_TIMER_3 + k] = events_in.basic_timer[k];
		slot_ev[`LINE_ADC] = events_in.adc;
		slot_ev[`LINE_COMPARATOR] = events_in.comparator;
		slot_ev[`LINE_DAC] = events_in.dac;
		slot_ev[`LINE_TOUCH_CONTROLLER] = events_in.touch_controller;
		slot_ev[`LINE_I2S] = events_in.i2s;
		slot_ev[`IRQ_NMI_SLOT] = events_in.ext_nmi;
	end

	////////////////////////////////////////////////////////////////
	// One flag and enable slot per line, plus one for the non-maskable sources.
	for (genvar g = 0; g < NUM_SLOTS; g++)
	begin : slot_gen
		irq_source_slot #(
			.SRC_W(SRC_W)
		) slot_inst (
			.clk_sys_in(clk_sys_in),
			.rst_in(rst_in),
			.event_in(slot_ev[g]),
			.flag_wr_in(sw_hit(sw_in, g, SEL_FLAG)),
			.en_set_wr_in(sw_hit(sw_in, g, SEL_EN_SET)),
			.en_clr_wr_in(sw_hit(sw_in, g, SEL_EN_CLR)),
			.wdata_in(sw_in.data),
			.flag_out(flag_all[g]),
			.enable_out(en_all[g]),
			.req_out(req_all[g])
		);
	end

	////////////////////////////////////////////////////////////////
	// Numbered lines go to the processor controller; the spare slot drives the non-maskable request.
	assign irq_lines_out = req_all[NUM_LINES-1:0];
	assign nmi_req_out = req_all[`IRQ_NMI_SLOT];

	////////////////////////////////////////////////////////////////
	// Read mux: both enable registers return the one shared mask.
	always_comb
	begin
		rd_data_next = '0;
		if (sw_in.slot < NUM_SLOTS)
		begin
			if (sw_in.sel == SEL_FLAG)
				rd_data_next = flag_all[sw_in.slot];
			else if (sw_in.sel == SEL_EN_SET || sw_in.sel == SEL_EN_CLR)
				rd_data_next = en_all[sw_in.slot];
		end
	end

	// Read data is captured on a read and held until the next one.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			rd_data_reg <= '0;
		else if (sw_in.rd)
			rd_data_reg <= rd_data_next;
	end

	// Valid marks the cycle after the read.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			rd_valid_reg <= 1'b0;
		else
			rd_valid_reg <= sw_in.rd;
	end

	assign rd_data_out = rd_data_reg;
	assign rd_valid_out = rd_valid_reg;

	////////////////////////////////////////////////////////////////
	// Checks on the flag, enable and routing behaviour.
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	// An event sets the flag even when a clear hits the same cycle.
	flag_set_a: assert property (slot_ev[2][0] |=> flag_all[2][0])
		else $error("flag not set by event");

	// Enable-set write turns on only the bits written as one.
	en_set_a: assert property (sw_hit(sw_in, 3, SEL_EN_SET) |=>
		en_all[3] == ($past(en_all[3]) | $past(sw_in.data)))
		else $error("enable set wrong");

	// Enable-clear write turns off only the bits written as one.
	en_clr_a: assert property (sw_hit(sw_in, 3, SEL_EN_CLR) |=>
		en_all[3] == ($past(en_all[3]) & ~$past(sw_in.data)))
		else $error("enable clear wrong");

	// Line level matches the OR of enabled flags of its slot.
	req_gate_a: assert property (irq_lines_out[5] == |(flag_all[5] & en_all[5]))
		else $error("line 5 does not match flags and enables");

	// Any enabled flag drives line 20 high.
	line_or_a: assert property ((|(flag_all[20] & en_all[20])) |-> irq_lines_out[20])
		else $error("line 20 low with enabled flag");

	// Power manager event reaches line 0 when enabled.
	map_pm_a: assert property (events_in.power_manager[0] && en_all[0][0]
		&& !sw_hit(sw_in, 0, SEL_EN_CLR) |=> irq_lines_out[0])
		else $error("power manager not on line 0");

	// Serial interface 2 reaches line 11.
	map_serial_a: assert property (events_in.serial_iface[2][0] && en_all[11][0]
		&& !sw_hit(sw_in, 11, SEL_EN_CLR) |=> irq_lines_out[11])
		else $error("serial interface 2 not on line 11");

	// Basic timer 7 reaches line 22.
	map_timer_a: assert property (events_in.basic_timer[4][0] && en_all[22][0]
		&& !sw_hit(sw_in, 22, SEL_EN_CLR) |=> irq_lines_out[22])
		else $error("basic timer 7 not on line 22");

	// I2S reaches line 27.
	map_i2s_a: assert property (events_in.i2s[0] && en_all[27][0]
		&& !sw_hit(sw_in, 27, SEL_EN_CLR) |=> irq_lines_out[27])
		else $error("i2s not on line 27");

	// Non-maskable source reaches the non-maskable output, not a line.
	map_nmi_a: assert property (events_in.ext_nmi[7] && en_all[`IRQ_NMI_SLOT][7]
		&& !sw_hit(sw_in, `IRQ_NMI_SLOT, SEL_EN_CLR) |=> nmi_req_out)
		else $error("non-maskable source lost");

	// Zero data written to an enable register leaves the mask as it was.
	en_zero_a: assert property ((sw_hit(sw_in, 6, SEL_EN_SET) || sw_hit(sw_in, 6, SEL_EN_CLR))
		&& sw_in.data == '0 |=> $stable(en_all[6]))
		else $error("zero write changed enables");

	// Reading the enable-clear register returns the mask.
	en_read_a: assert property (sw_in.rd && sw_in.sel == SEL_EN_CLR && sw_in.slot == 5'h03
		|=> rd_valid_out && rd_data_out == $past(en_all[3]))
		else $error("enable read back wrong");

	// A flag holds unless a one is written to it.
	flag_hold_a: assert property (flag_all[6][5] && !(sw_hit(sw_in, 6, SEL_FLAG) && sw_in.data[5])
		|=> flag_all[6][5])
		else $error("flag dropped without clear");

	// A written one with no event clears the flag.
	flag_clr_a: assert property (sw_hit(sw_in, 6, SEL_FLAG) && sw_in.data[5] && !slot_ev[6][5]
		|=> !flag_all[6][5])
		else $error("flag clear ignored");

	// System control reaches line 1.
	map_sysctl_a: assert property (events_in.system_control[0] && en_all[1][0]
		&& !sw_hit(sw_in, 1, SEL_EN_CLR) |=> irq_lines_out[1])
		else $error("system control not on line 1");

	// Watchdog reaches line 2.
	map_wdog_a: assert property (events_in.watchdog[0] && en_all[2][0]
		&& !sw_hit(sw_in, 2, SEL_EN_CLR) |=> irq_lines_out[2])
		else $error("watchdog not on line 2");

	// Real-time counter reaches line 3.
	map_rtc_a: assert property (events_in.rtc[0] && en_all[3][0]
		&& !sw_hit(sw_in, 3, SEL_EN_CLR) |=> irq_lines_out[3])
		else $error("real-time counter not on line 3");

	// Maskable external interrupts reach line 4.
	map_extirq_a: assert property (events_in.external_irq_unit[0] && en_all[4][0]
		&& !sw_hit(sw_in, 4, SEL_EN_CLR) |=> irq_lines_out[4])
		else $error("external interrupts not on line 4");

	// Flash controller reaches line 5.
	map_flash_a: assert property (events_in.flash_controller[0] && en_all[5][0]
		&& !sw_hit(sw_in, 5, SEL_EN_CLR) |=> irq_lines_out[5])
		else $error("flash controller not on line 5");

	// DMA controller reaches line 6.
	map_dma_a: assert property (events_in.dma_controller[0] && en_all[6][0]
		&& !sw_hit(sw_in, 6, SEL_EN_CLR) |=> irq_lines_out[6])
		else $error("dma controller not on line 6");

	// USB reaches line 7.
	map_usb_a: assert property (events_in.usb[0] && en_all[7][0]
		&& !sw_hit(sw_in, 7, SEL_EN_CLR) |=> irq_lines_out[7])
		else $error("usb not on line 7");

	// Event system reaches line 8.
	map_event_a: assert property (events_in.event_system[0] && en_all[8][0]
		&& !sw_hit(sw_in, 8, SEL_EN_CLR) |=> irq_lines_out[8])
		else $error("event system not on line 8");

	// Serial interface 0 reaches line 9.
	map_serial0_a: assert property (events_in.serial_iface[0][0] && en_all[9][0]
		&& !sw_hit(sw_in, 9, SEL_EN_CLR) |=> irq_lines_out[9])
		else $error("serial interface 0 not on line 9");

	// Serial interface 5 reaches line 14.
	map_serial5_a: assert property (events_in.serial_iface[5][0] && en_all[14][0]
		&& !sw_hit(sw_in, 14, SEL_EN_CLR) |=> irq_lines_out[14])
		else $error("serial interface 5 not on line 14");

	// Control timer 0 reaches line 15.
	map_ctimer0_a: assert property (events_in.control_timer[0][0] && en_all[15][0]
		&& !sw_hit(sw_in, 15, SEL_EN_CLR) |=> irq_lines_out[15])
		else $error("control timer 0 not on line 15");

	// Control timer 2 reaches line 17.
	map_ctimer2_a: assert property (events_in.control_timer[2][0] && en_all[17][0]
		&& !sw_hit(sw_in, 17, SEL_EN_CLR) |=> irq_lines_out[17])
		else $error("control timer 2 not on line 17");

	// Basic timer 3 reaches line 18.
	map_btimer3_a: assert property (events_in.basic_timer[0][0] && en_all[18][0]
		&& !sw_hit(sw_in, 18, SEL_EN_CLR) |=> irq_lines_out[18])
		else $error("basic timer 3 not on line 18");

	// Converter reaches line 23.
	map_adc_a: assert property (events_in.adc[0] && en_all[23][0]
		&& !sw_hit(sw_in, 23, SEL_EN_CLR) |=> irq_lines_out[23])
		else $error("adc not on line 23");

	// Comparator reaches line 24.
	map_comp_a: assert property (events_in.comparator[0] && en_all[24][0]
		&& !sw_hit(sw_in, 24, SEL_EN_CLR) |=> irq_lines_out[24])
		else $error("comparator not on line 24");

	// Output converter reaches line 25.
	map_dac_a: assert property (events_in.dac[0] && en_all[25][0]
		&& !sw_hit(sw_in, 25, SEL_EN_CLR) |=> irq_lines_out[25])
		else $error("dac not on line 25");

	// Touch controller reaches line 26.
	map_touch_a: assert property (events_in.touch_controller[0] && en_all[26][0]
		&& !sw_hit(sw_in, 26, SEL_EN_CLR) |=> irq_lines_out[26])
		else $error("touch controller not on line 26");

	// Main scenarios worth seeing.
	nmi_seen_c: cover property (nmi_req_out);
	i2s_rise_c: cover property ($rose(irq_lines_out[27]));
	clr_race_c: cover property (sw_hit(sw_in, 2, SEL_FLAG) && sw_in.data[0] && slot_ev[2][0]);
	line_drop_c: cover property ($fell(irq_lines_out[9]));

endmodule

// ===== irq_defines.svh
// Constants for the peripheral interrupt aggregation block.
`ifndef IRQ_DEFINES_SVH
`define IRQ_DEFINES_SVH

// Sources per peripheral and number of numbered request lines.
`define IRQ_SRC_W 8
`define IRQ_NUM_LINES 28
`define IRQ_LINE_IDX_W 5

// Extra slot that holds the non-maskable sources.
`define IRQ_NMI_SLOT 28
`define IRQ_NUM_SLOTS 29

// Reset values of the flag and enable registers.
`define IRQ_FLAG_RESET 8'h00
`define IRQ_EN_RESET 8'h00

// Request line of each peripheral.
`define LINE_POWER_MANAGER 0
`define LINE_SYSTEM_CONTROL 1
`define LINE_WATCHDOG 2
`define LINE_RTC 3
`define LINE_EXTERNAL_IRQ_UNIT 4
`define LINE_FLASH_CONTROLLER 5
`define LINE_DMA_CONTROLLER 6
`define LINE_USB 7
`define LINE_EVENT_SYSTEM 8
`define LINE_SERIAL_IFACE_0 9
`define NUM_SERIAL_IFACE 6
`define LINE_CONTROL_TIMER_0 15
`define NUM_CONTROL_TIMER 3
`define LINE_BASIC_TIMER_3 18
`define NUM_BASIC_TIMER 5
`define LINE_ADC 23
`define LINE_COMPARATOR 24
`define LINE_DAC 25
`define LINE_TOUCH_CONTROLLER 26
`define LINE_I2S 27

`endif

// ===== irq_pkg.sv
// Types shared by the peripheral interrupt aggregation block.
`include "irq_defines.svh"

package irq_pkg;

	// Register selected by a software access.
	typedef enum logic [1:0] {
		SEL_FLAG = 2'h0,
		SEL_EN_SET = 2'h1,
		SEL_EN_CLR = 2'h3
	} reg_sel_t;

	typedef logic [`IRQ_SRC_W-1:0] src_vec_t;

	// One software register access, addressed by slot number.
	typedef struct packed {
		logic wr;
		logic rd;
		reg_sel_t sel;
		logic [`IRQ_LINE_IDX_W-1:0] slot;
		src_vec_t data;
	} sw_access_t;

	// Interrupt condition pulses of every peripheral, one bit per source.
	typedef struct packed {
		src_vec_t power_manager;
		src_vec_t system_control;
		src_vec_t watchdog;
		src_vec_t rtc;
		src_vec_t external_irq_unit;
		src_vec_t ext_nmi;
		src_vec_t flash_controller;
		src_vec_t dma_controller;
		src_vec_t usb;
		src_vec_t event_system;
		src_vec_t [`NUM_SERIAL_IFACE-1:0] serial_iface;
		src_vec_t [`NUM_CONTROL_TIMER-1:0] control_timer;
		src_vec_t [`NUM_BASIC_TIMER-1:0] basic_timer;
		src_vec_t adc;
		src_vec_t comparator;
		src_vec_t dac;
		src_vec_t touch_controller;
		src_vec_t i2s;
	} periph_events_t;

endpackage

// ===== irq_source_slot.sv
// Flag and enable registers of one peripheral with its request output.
`timescale 1ns/100ps
`include "irq_defines.svh"

module irq_source_slot #(
	parameter int SRC_W = `IRQ_SRC_W
) (
	input wire logic clk_sys_in, // System clock.
	input wire logic rst_in, // Asynchronous reset, active high.
	input wire logic [SRC_W-1:0] event_in, // Interrupt condition pulses.
	input wire logic flag_wr_in, // Write to the flag register.
	input wire logic en_set_wr_in, // Write to the enable-set register.
	input wire logic en_clr_wr_in, // Write to the enable-clear register.
	input wire logic [SRC_W-1:0] wdata_in, // Write data.
	output logic [SRC_W-1:0] flag_out, // Current flags.
	output logic [SRC_W-1:0] enable_out, // Current enable mask.
	output logic req_out // Request of this peripheral.
);

	logic [SRC_W-1:0] irq_flag_reg;
	logic [SRC_W-1:0] irq_flag_next;
	logic [SRC_W-1:0] irq_enable_reg;
	logic [SRC_W-1:0] irq_enable_next;

	////////////////////////////////////////////////////////////////
	// A one written clears a flag, but a new event in the same cycle wins.
	always_comb
	begin
		irq_flag_next = irq_flag_reg;
		if (flag_wr_in)
		begin
			irq_flag_next = irq_flag_reg & ~wdata_in;
		end
		irq_flag_next = irq_flag_next | event_in;
	end

	// Flag storage.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			irq_flag_reg <= SRC_W'(`IRQ_FLAG_RESET);
		else
			irq_flag_reg <= irq_flag_next;
	end

	////////////////////////////////////////////////////////////////
	// Set and clear writes share one mask; zero bits leave it alone.
	always_comb
	begin
		irq_enable_next = irq_enable_reg;
		if (en_set_wr_in)
			irq_enable_next = irq_enable_reg | wdata_in;
		else if (en_clr_wr_in)
			irq_enable_next = irq_enable_reg & ~wdata_in;
	end

	// Enable storage.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			irq_enable_reg <= SRC_W'(`IRQ_EN_RESET);
		else
			irq_enable_reg <= irq_enable_next;
	end

	////////////////////////////////////////////////////////////////
	// Request stands while any enabled source has its flag up.
	assign req_out = |(irq_flag_reg & irq_enable_reg);
	assign flag_out = irq_flag_reg;
	assign enable_out = irq_enable_reg;

endmodule

// ===== cpu_irq_controller.sv
// Behavioural model of the processor's nested interrupt controller.
`timescale 1ns/100ps

module cpu_irq_controller (
	input wire logic clk_sys_in, // System clock.
	input wire logic rst_in, // Asynchronous reset, active high.
	input wire logic [27:0] irq_lines_in, // Peripheral request lines.
	input wire logic nmi_req_in, // Non-maskable request.
	input wire logic [27:0] line_enable_set_bits_in, // Line enables to set.
	input wire logic [27:0] pending_clear_bits_in, // Pending bits to clear.
	output logic [27:0] pending_out, // Pending lines.
	output logic [27:0] active_out, // Pending and enabled lines.
	output logic nmi_out // Non-maskable request seen.
);
	logic [27:0] pending_set_reg;
	logic [27:0] line_enable_set_reg;
	logic [7:0][31:0] line_priority_regs;

	////////////////////////////////////////////////////////////////////////////////
	// A high line latches its pending bit; a clear wins only once the line is low.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			pending_set_reg <= 28'h0000000;
		else
			pending_set_reg <= (pending_set_reg & ~pending_clear_bits_in) | irq_lines_in;
	end

	// Line enables are kept here, apart from the peripheral masks.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			line_enable_set_reg <= 28'h0000000;
		else
			line_enable_set_reg <= line_enable_set_reg | line_enable_set_bits_in;
	end

	// One priority field per line in eight words; software never changes them here.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			line_priority_regs <= '0;
		else
			line_priority_regs <= line_priority_regs;
	end

	// A line becomes active only when pending and enabled.
	assign pending_out = pending_set_reg;
	assign active_out = pending_set_reg & line_enable_set_reg;
	assign nmi_out = nmi_req_in;
endmodule

// ===== tb_peripheral_irq_aggregation.sv
// Self-checking testbench for the peripheral interrupt aggregation block.
`timescale 1ns/100ps

module tb_peripheral_irq_aggregation;
	import irq_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	periph_events_t ev = '0;
	sw_access_t sw = '0;
	logic [7:0] rdata;
	logic rvalid;
	logic [27:0] lines;
	logic nmi;
	logic [27:0] en_set = '0;
	logic [27:0] pend_clr = '0;
	logic [27:0] pend;
	logic [27:0] act;
	int bad_count = 0;
	int check_count = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Block under test and the processor side model.
	peripheral_irq_aggregation uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .events_in(ev), .sw_in(sw),
		.rd_data_out(rdata), .rd_valid_out(rvalid), .irq_lines_out(lines), .nmi_req_out(nmi));
	cpu_irq_controller cpu (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .irq_lines_in(lines), .nmi_req_in(nmi),
		.line_enable_set_bits_in(en_set), .pending_clear_bits_in(pend_clr), .pending_out(pend),
		.active_out(act), .nmi_out());

	// Clock of 8 ns period.
	always #4 clk_sys_in = ~clk_sys_in;

	////////////////////////////////////////////////////////////////////////////////
	// Field index, counted from the low end of the event struct, for each line.
	function automatic int fidx(input int l);
		if (l < 5) return 28 - l;
		if (l < 8) return 27 - l;
		if (l == 8) return 19;
		if (l < 15) return l + 4;
		if (l < 18) return l - 5;
		if (l < 23) return l - 13;
		return 27 - l;
	endfunction

	// Compares one value and counts it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One software access held for a single edge.
	task automatic acc(input logic w, input logic r, input reg_sel_t s, input int n, input logic [7:0] d);
		@(posedge clk_sys_in);
		sw <= '{wr: w, rd: r, sel: s, slot: 5'(n), data: d};
		@(posedge clk_sys_in);
		sw <= '0;
		#1;
	endtask

	task automatic wr(input reg_sel_t s, input int n, input logic [7:0] d);
		acc(1'b1, 1'b0, s, n, d);
	endtask

	// Read; the answer is due exactly one cycle after the request.
	task automatic rchk(input reg_sel_t s, input int n, input logic [7:0] exp);
		acc(1'b0, 1'b1, s, n, 8'h00);
		chk(rvalid, 1);
		chk(rdata, exp);
	endtask

	// One-cycle event pulse on field k.
	task automatic pulse(input int k, input logic [7:0] b);
		logic [$bits(periph_events_t)-1:0] v;
		v = '0;
		v[7:0] = b;
		v = v << (8 * k);
		@(posedge clk_sys_in);
		ev <= v;
		@(posedge clk_sys_in);
		ev <= '0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Quiet outputs and zero masks out of reset.
	task automatic t_reset();
		chk(lines, 0);
		chk(nmi, 0);
		rchk(SEL_EN_SET, 0, 8'h00);
		rchk(SEL_FLAG, 0, 8'h00);
	endtask

	// Every peripheral reaches its own line only, and the processor sees it.
	task automatic t_map();
		for (int l = 0; l < 28; l++)
		begin
			wr(SEL_EN_SET, l, 8'h01);
			pulse(fidx(l), 8'h01);
			chk(lines, 32'h1 << l);
			@(posedge clk_sys_in);
			#1;
			chk(pend[l], 1);
			chk(act[l], l % 2 == 0);
			wr(SEL_FLAG, l, 8'h01);
			chk(lines, 0);
			@(posedge clk_sys_in);
			pend_clr <= '1;
			@(posedge clk_sys_in);
			pend_clr <= '0;
		end
	endtask

	// The non-maskable sources use their own output.
	task automatic t_nmi();
		wr(SEL_EN_SET, 28, 8'h80);
		pulse(23, 8'h80);
		chk(nmi, 1);
		chk(lines, 0);
		wr(SEL_FLAG, 28, 8'h80);
		chk(nmi, 0);
	endtask

	// Shared mask, zero writes, disabled flags and the OR of sources.
	task automatic t_mask();
		wr(SEL_EN_SET, 6, 8'hA5);
		wr(SEL_EN_SET, 6, 8'h00);
		rchk(SEL_EN_SET, 6, 8'hA5);
		wr(SEL_EN_CLR, 6, 8'h05);
		wr(SEL_EN_CLR, 6, 8'h00);
		rchk(SEL_EN_CLR, 6, 8'hA0);
		rchk(SEL_EN_SET, 6, 8'hA0);
		pulse(fidx(6), 8'h01);
		chk(lines, 0);
		rchk(SEL_FLAG, 6, 8'h01);
		pulse(fidx(6), 8'hA0);
		chk(lines, 32'h40);
		wr(SEL_FLAG, 6, 8'h20);
		chk(lines, 32'h40);
		wr(SEL_FLAG, 6, 8'h00);
		rchk(SEL_FLAG, 6, 8'h81);
		wr(SEL_EN_CLR, 6, 8'h80);
		chk(lines, 0);
		wr(SEL_FLAG, 6, 8'h81);
		rchk(SEL_FLAG, 6, 8'h00);
	endtask

	// Unmapped select and slot change nothing and read zero.
	task automatic t_refuse();
		wr(reg_sel_t'(2'h2), 6, 8'hFF);
		rchk(SEL_EN_SET, 6, 8'h20);
		rchk(reg_sel_t'(2'h2), 6, 8'h00);
		wr(SEL_EN_SET, 29, 8'hFF);
		rchk(SEL_EN_SET, 29, 8'h00);
	endtask

	// Event against clear in one cycle, then a read beside a write.
	task automatic t_race();
		@(posedge clk_sys_in);
		ev.watchdog <= 8'h01;
		sw <= '{wr: 1'b1, rd: 1'b0, sel: SEL_FLAG, slot: 5'h02, data: 8'h01};
		@(posedge clk_sys_in);
		ev <= '0;
		sw <= '0;
		#1;
		chk(lines, 32'h4);
		wr(SEL_FLAG, 2, 8'h01);
		chk(lines, 0);
		acc(1'b1, 1'b1, SEL_EN_CLR, 3, 8'h01);
		chk(rdata, 8'h01);
		rchk(SEL_EN_SET, 3, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence.
	initial
	begin
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		en_set <= 28'h5555555;
		#1;
		t_reset();
		t_map();
		t_nmi();
		t_mask();
		t_refuse();
		t_race();
		stop_test();
	end

	// Watchdog well beyond the expected run length.
	initial
	begin
		#40000;
		bad_count++;
		stop_test();
	end
endmodule
